// *** nfr_params.svh ***
`ifndef NFR_PARAMS_SVH
`define NFR_PARAMS_SVH

// ============================================================
// register indices (byte address is four times the index)
`define NFR_IDX_FDC        8'h23
`define NFR_IDX_SYS        8'h24
`define NFR_IDX_TEMP       8'h25
`define NFR_IDX_GAIN       8'h26
`define NFR_IDX_INT_STAT   8'h30
`define NFR_IDX_INT_MASK   8'h31

// ============================================================
// field positions and writable masks
`define NFR_FDC_PD         14
`define NFR_FDC_SRC_LSB    12
`define NFR_FDC_LVL_LSB    8
`define NFR_FDC_REFA_LSB   4
`define NFR_FDC_REFB_LSB   0
`define NFR_FDC_WMASK      32'h0000_7FFF
`define NFR_SYS_REG_GOOD   9
`define NFR_SYS_PARAM_ERR  8
`define NFR_SYS_SYNTAX_ERR 7
`define NFR_SYS_SEMAN_ERR  6
`define NFR_SYS_STBY_BLK   5
`define NFR_SYS_BOOT_LSB   0
`define NFR_TEMP_HYST      3
`define NFR_TEMP_EN        2
`define NFR_TEMP_THR_LSB   0
`define NFR_TEMP_WMASK     32'h0000_000F
`define NFR_GAIN_GEAR_LSB  10
`define NFR_GAIN_VAL_LSB   0
`define NFR_INT_CAL_DONE   0
`define NFR_INT_HOST_ERR   1
`define NFR_INT_STBY_BLK   2
`define NFR_INT_WMASK      32'h0000_0007

// ============================================================
// reset values and constants
`define NFR_RST_WORD       32'h0000_0000
`define NFR_TRIP_0         8'd85
`define NFR_TRIP_1         8'd115
`define NFR_TRIP_2         8'd125
`define NFR_TRIP_3         8'd135
`define NFR_RESP_OKAY      2'b00
`define NFR_RESP_SLVERR    2'b10

`endif

// *** nfr_pkg.sv ***
package nfr_pkg;

    typedef enum logic [2:0] {
        NFR_RD_IDLE = 3'b001,
        NFR_RD_CAL  = 3'b010,
        NFR_RD_RESP = 3'b100
    } nfr_rd_e;

    typedef enum logic [1:0] {
        NFR_CAL_IDLE = 2'b01,
        NFR_CAL_REQ  = 2'b10
    } nfr_cal_e;

    typedef enum logic [1:0] {
        NFR_SRC_NEAR  = 2'b00,
        NFR_SRC_LEVEL = 2'b01,
        NFR_SRC_BOTH  = 2'b10,
        NFR_SRC_FORCE = 2'b11
    } nfr_src_e;

endpackage

// *** nfr_cal_seq.sv ***
module nfr_cal_seq
    import nfr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       start_i,
    input  wire logic       fixed_i,
    input  wire logic [3:0] gear_i,
    output logic            busy_o,
    output logic            done_o,
    output logic [3:0]      gear_o,
    output logic [9:0]      value_o,
    output logic            cal_req_o,
    output logic            cal_fixed_gear_o,
    output logic [3:0]      cal_gear_o,
    input  wire logic       cal_ack_i,
    input  wire logic [3:0] cal_gear_res_i,
    input  wire logic [9:0] cal_value_res_i
);

    nfr_cal_e state_q;

    // ============================================================
    // sequencer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q          <= NFR_CAL_IDLE;
            cal_fixed_gear_o <= 1'b0;
            cal_gear_o       <= 4'h0;
        end else begin
            case (state_q)
                NFR_CAL_IDLE: begin
                    if (start_i) begin
                        state_q          <= NFR_CAL_REQ;
                        cal_fixed_gear_o <= fixed_i;
                        cal_gear_o       <= gear_i;
                    end
                end
                NFR_CAL_REQ: begin
                    if (cal_ack_i) begin
                        state_q <= NFR_CAL_IDLE;
                    end
                end
                default: state_q <= NFR_CAL_IDLE;
            endcase
        end
    end

    assign cal_req_o = (state_q == NFR_CAL_REQ);
    assign busy_o    = cal_req_o;
    assign done_o    = cal_req_o & cal_ack_i;
    // a fixed gear survives the run; otherwise take the measured one
    assign gear_o    = cal_fixed_gear_o ? cal_gear_o : cal_gear_res_i;
    assign value_o   = cal_value_res_i;

endmodule

// *** nfr_status_config_regs.sv ***
// Overview of operation
// R1: Source select picks near-field, level, both, or a forced detection.
// R2: The powerdown bit switches the near-field detector off.
// R3: Level setting and two level references are writable, reset to zero.
// R4: Status bit 9 follows the regulator-output-good input.
// R5: Parameter, syntax and semantic host errors show in bits 8, 7, 6.
// R6: Bit 5 is set when standby is refused because a field is detected.
// R7: Bits 4 to 0 hold the boot cause of the last start-up.
// R8: Temperature bit 3 enables hysteresis and bit 2 the sensor.
// R9: The threshold code selects a trip of 85, 115, 125 or 135 degrees.
// R10: Gear bits 13:10 are written by software or set by a calibration.
// R11: Value bits 9:0 come only from calibration; writes to them do nothing.
// R12: A gain read with no prior write starts a calibration.
// R13: That read returns the new value together with the gear.
// R14: The host writes back the read value before card detection.
// R15: The host always reads the gain register first, then writes it.
// R16: Reserved bits read zero; writes to them and to status are ignored.
`include "nfr_params.svh"
module nfr_status_config_regs
    import nfr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] s_awaddr_i,
    input  wire logic              s_awvalid_i,
    output logic                   s_awready_o,
    input  wire logic [31:0]       s_wdata_i,
    input  wire logic [3:0]        s_wstrb_i,
    input  wire logic              s_wvalid_i,
    output logic                   s_wready_o,
    output logic [1:0]             s_bresp_o,
    output logic                   s_bvalid_o,
    input  wire logic              s_bready_i,
    input  wire logic [ADDR_W-1:0] s_araddr_i,
    input  wire logic              s_arvalid_i,
    output logic                   s_arready_o,
    output logic [31:0]            s_rdata_o,
    output logic [1:0]             s_rresp_o,
    output logic                   s_rvalid_o,
    input  wire logic              s_rready_i,
    input  wire logic              nfc_level_det_i,
    input  wire logic              rf_level_det_i,
    output logic                   near_field_detector_powerdown_o,
    output logic                   field_detected_o,
    output logic [3:0]             detection_level_setting_o,
    output logic [3:0]             level_detector_ref_a_o,
    output logic [3:0]             level_detector_ref_b_o,
    input  wire logic              regulator_output_good_i,
    input  wire logic              host_param_err_i,
    input  wire logic              host_syntax_err_i,
    input  wire logic              host_semantic_err_i,
    input  wire logic              host_err_clear_i,
    input  wire logic              standby_req_i,
    input  wire logic [4:0]        boot_cause_i,
    output logic                   thermal_hysteresis_enable_o,
    output logic                   temp_sensor_enable_o,
    output logic [7:0]             temp_trip_deg_o,
    output logic                   cal_req_o,
    output logic                   cal_fixed_gear_o,
    output logic [3:0]             cal_gear_o,
    input  wire logic              cal_ack_i,
    input  wire logic [3:0]        cal_gear_res_i,
    input  wire logic [9:0]        cal_value_res_i,
    output logic                   irq_o
);

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // word_idx reads address bits 9:2
    if (ADDR_W < 10) begin : g_addr_chk
        $error("ADDR_W must be at least 10");
    end

    function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
        return a[9:2];
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic idx_ok(input logic [7:0] i);
        return i inside {`NFR_IDX_FDC, `NFR_IDX_SYS, `NFR_IDX_TEMP,
                         `NFR_IDX_GAIN, `NFR_IDX_INT_STAT,
                         `NFR_IDX_INT_MASK};
    endfunction

    // ============================================================
    // storage
    logic [31:0] fdc_q;
    logic [3:0]  temp_q;
    logic [3:0]  gear_q;
    logic [9:0]  value_q;
    logic [2:0]  host_err_q;
    logic        stby_q;
    logic [4:0]  boot_q;
    logic        boot_done_q;
    logic        field_det_q;
    logic [7:0]  trip_q;
    logic [2:0]  int_stat_q;
    logic [2:0]  int_mask_q;
    logic        written_q;

    // ============================================================
    // write channel
    logic              aw_q;
    logic              w_q;
    logic [7:0]        widx_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              do_wr;
    logic [31:0]       wm;
    logic              cal_busy;
    logic              cal_done;
    logic [3:0]        cal_gear;
    logic [9:0]        cal_value;
    logic              rd_cal_start;
    logic              wr_cal_start;

    // register bus stalls writes while a calibration runs
    assign do_wr = aw_q & w_q & ~bvalid_q & ~cal_busy & ~rd_cal_start;
    assign wm    = strb_mask(wstrb_q);
    assign s_awready_o = ~aw_q;
    assign s_wready_o  = ~w_q;
    assign s_bvalid_o  = bvalid_q;
    assign s_bresp_o   = bresp_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            widx_q   <= 8'h00;
            wdata_q  <= `NFR_RST_WORD;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= `NFR_RESP_OKAY;
        end else begin
            if (s_awvalid_i && !aw_q) begin
                aw_q   <= 1'b1;
                widx_q <= word_idx(s_awaddr_i);
            end
            if (s_wvalid_i && !w_q) begin
                w_q     <= 1'b1;
                wdata_q <= s_wdata_i;
                wstrb_q <= s_wstrb_i;
            end
            if (do_wr) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= idx_ok(widx_q) ? `NFR_RESP_OKAY
                                           : `NFR_RESP_SLVERR;
            end else if (bvalid_q && s_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ============================================================
    // configuration registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fdc_q  <= `NFR_RST_WORD;
            temp_q <= 4'h0;
        end else if (do_wr) begin
            // R3: level fields writable
            if (widx_q == `NFR_IDX_FDC) begin
                fdc_q <= (fdc_q & ~(wm & `NFR_FDC_WMASK))
                       | (wdata_q & wm & `NFR_FDC_WMASK);
            end
            // R8: enables writable
            if (widx_q == `NFR_IDX_TEMP) begin
                temp_q <= (temp_q & ~wm[3:0])
                        | (wdata_q[3:0] & wm[3:0]);
            end
        end
    end

    AST_TEMP_EN: assert property ( // R8
        do_wr && widx_q == `NFR_IDX_TEMP && wstrb_q[0]
        |=> temp_sensor_enable_o == $past(wdata_q[2]))
        else $error("sensor enable not written");

    assign near_field_detector_powerdown_o = fdc_q[`NFR_FDC_PD];
    assign detection_level_setting_o = fdc_q[`NFR_FDC_LVL_LSB +: 4];
    assign level_detector_ref_a_o    = fdc_q[`NFR_FDC_REFA_LSB +: 4];
    assign level_detector_ref_b_o    = fdc_q[`NFR_FDC_REFB_LSB +: 4];
    assign thermal_hysteresis_enable_o = temp_q[`NFR_TEMP_HYST];
    assign temp_sensor_enable_o        = temp_q[`NFR_TEMP_EN];
    assign temp_trip_deg_o             = trip_q;
    assign field_detected_o            = field_det_q;

    // ============================================================
    // field detection and thermal trip
    logic near_det;
    // R2: powerdown gates detector
    assign near_det = nfc_level_det_i & ~fdc_q[`NFR_FDC_PD];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            field_det_q <= 1'b0;
            trip_q      <= `NFR_TRIP_0;
        end else begin
            // R1: source select
            case (nfr_src_e'(fdc_q[`NFR_FDC_SRC_LSB +: 2]))
                NFR_SRC_NEAR:  field_det_q <= near_det;
                NFR_SRC_LEVEL: field_det_q <= rf_level_det_i;
                NFR_SRC_BOTH:  field_det_q <= near_det | rf_level_det_i;
                NFR_SRC_FORCE: field_det_q <= 1'b1;
                default:       field_det_q <= 1'b0;
            endcase
            // R9: trip selection
            case (temp_q[`NFR_TEMP_THR_LSB +: 2])
                2'b00:   trip_q <= `NFR_TRIP_0;
                2'b01:   trip_q <= `NFR_TRIP_1;
                2'b10:   trip_q <= `NFR_TRIP_2;
                default: trip_q <= `NFR_TRIP_3;
            endcase
        end
    end

    AST_SRC_FORCE: assert property ( // R1
        fdc_q[13:12] == 2'b11 |=> field_det_q)
        else $error("forced source did not detect");
    AST_PD_GATE: assert property ( // R2
        fdc_q[14] && fdc_q[13:12] == 2'b00 |=> !field_det_q)
        else $error("powered-down detector still reports");
    AST_TRIP: assert property ( // R9
        temp_q[1:0] == 2'b11 ##1 temp_q[1:0] == 2'b11
        |-> trip_q == 8'd135)
        else $error("trip temperature wrong");

    // ============================================================
    // system status
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_err_q  <= 3'b000;
            stby_q      <= 1'b0;
            boot_q      <= 5'h00;
            boot_done_q <= 1'b0;
        end else begin
            // R5: sticky errors, a new error beats the clear
            host_err_q <= (host_err_q & {3{~host_err_clear_i}})
                        | {host_param_err_i, host_syntax_err_i,
                           host_semantic_err_i};
            // R6: refused standby
            if (standby_req_i) begin
                stby_q <= field_det_q;
            end
            // R7: boot cause caught once after release
            if (!boot_done_q) begin
                boot_done_q <= 1'b1;
                boot_q      <= boot_cause_i;
            end
        end
    end

    AST_HOST_ERR: assert property ( // R5
        host_param_err_i |=> host_err_q[2] [*2] or host_err_clear_i)
        else $error("parameter error not held");
    AST_STBY: assert property ( // R6
        standby_req_i && field_det_q |=> stby_q)
        else $error("refused standby not flagged");
    AST_BOOT: assert property ( // R7
        $rose(boot_done_q) |-> boot_q == $past(boot_cause_i))
        else $error("boot cause not captured");

    // ============================================================
    // gain reference and calibration
    logic ar_hs;
    logic ar_gain;
    nfr_rd_e rd_state_q;

    assign ar_hs        = s_arvalid_i & (rd_state_q == NFR_RD_IDLE);
    assign ar_gain      = word_idx(s_araddr_i) == `NFR_IDX_GAIN;
    // R12: read without prior write calibrates
    assign rd_cal_start = ar_hs & ar_gain & ~written_q & ~cal_busy;
    assign wr_cal_start = do_wr & (widx_q == `NFR_IDX_GAIN);

    nfr_cal_seq u_cal (
        .clk_i            (clk_i),
        .rst_b_i          (rst_b_i),
        .start_i          (rd_cal_start | wr_cal_start),
        .fixed_i          (wr_cal_start),
        .gear_i           (wdata_q[`NFR_GAIN_GEAR_LSB +: 4]),
        .busy_o           (cal_busy),
        .done_o           (cal_done),
        .gear_o           (cal_gear),
        .value_o          (cal_value),
        .cal_req_o        (cal_req_o),
        .cal_fixed_gear_o (cal_fixed_gear_o),
        .cal_gear_o       (cal_gear_o),
        .cal_ack_i        (cal_ack_i),
        .cal_gear_res_i   (cal_gear_res_i),
        .cal_value_res_i  (cal_value_res_i)
    );

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gear_q    <= 4'h0;
            value_q   <= 10'h000;
            written_q <= 1'b0;
        end else begin
            // R10: gear from software or calibration
            if (cal_done) begin
                gear_q  <= cal_gear;
                // R11: value only from calibration
                value_q <= cal_value;
            end else if (wr_cal_start && wm[`NFR_GAIN_GEAR_LSB]) begin
                gear_q <= wdata_q[`NFR_GAIN_GEAR_LSB +: 4];
            end
            // the pairing resets on read so the next read recalibrates
            if (wr_cal_start) begin
                written_q <= 1'b1;
            end else if (ar_hs && ar_gain) begin
                written_q <= 1'b0;
            end
        end
    end

    AST_VALUE_RO: assert property ( // R11
        wr_cal_start |=> value_q == $past(value_q))
        else $error("software write changed gain value");
    AST_READ_CAL: assert property ( // R12
        rd_cal_start |=> cal_req_o && rd_state_q == NFR_RD_CAL)
        else $error("read did not start calibration");

    // ============================================================
    // interrupts
    logic [2:0] int_ev;
    logic [2:0] int_clr;
    assign int_ev  = {standby_req_i & field_det_q,
                      host_param_err_i | host_syntax_err_i
                      | host_semantic_err_i,
                      cal_done};
    assign int_clr = (do_wr && widx_q == `NFR_IDX_INT_STAT)
                   ? (wdata_q[2:0] & wm[2:0]) : 3'b000;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_stat_q <= 3'b000;
            int_mask_q <= 3'b000;
        end else begin
            // an event in the clearing cycle stays set
            int_stat_q <= (int_stat_q & ~int_clr) | int_ev;
            if (do_wr && widx_q == `NFR_IDX_INT_MASK) begin
                int_mask_q <= (int_mask_q & ~wm[2:0])
                            | (wdata_q[2:0] & wm[2:0]);
            end
        end
    end

    assign irq_o = |(int_stat_q & int_mask_q);

    // ============================================================
    // read channel
    logic [31:0] rd_mux;
    logic [7:0]  ridx_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [7:0]  ridx;

    assign ridx = (rd_state_q == NFR_RD_IDLE) ? word_idx(s_araddr_i)
                                              : ridx_q;

    // R16: reserved bits read zero
    always_comb begin
        rd_mux = `NFR_RST_WORD;
        case (ridx)
            `NFR_IDX_FDC:  rd_mux = fdc_q & `NFR_FDC_WMASK;
            `NFR_IDX_SYS: begin
                // R4: regulator good follows the pin
                rd_mux[`NFR_SYS_REG_GOOD] = regulator_output_good_i;
                rd_mux[`NFR_SYS_PARAM_ERR] = host_err_q[2];
                rd_mux[`NFR_SYS_SYNTAX_ERR] = host_err_q[1];
                rd_mux[`NFR_SYS_SEMAN_ERR] = host_err_q[0];
                rd_mux[`NFR_SYS_STBY_BLK] = stby_q;
                rd_mux[`NFR_SYS_BOOT_LSB +: 5] = boot_q;
            end
            `NFR_IDX_TEMP: rd_mux[3:0] = temp_q;
            // R13: gear and value returned together
            `NFR_IDX_GAIN: begin
                rd_mux[`NFR_GAIN_GEAR_LSB +: 4] = gear_q;
                rd_mux[`NFR_GAIN_VAL_LSB +: 10] = value_q;
            end
            `NFR_IDX_INT_STAT: rd_mux[2:0] = int_stat_q;
            `NFR_IDX_INT_MASK: rd_mux[2:0] = int_mask_q;
            default:           rd_mux = `NFR_RST_WORD;
        endcase
    end

    assign s_arready_o = (rd_state_q == NFR_RD_IDLE);
    assign s_rvalid_o  = (rd_state_q == NFR_RD_RESP);
    assign s_rdata_o   = rdata_q;
    assign s_rresp_o   = rresp_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_state_q <= NFR_RD_IDLE;
            ridx_q     <= 8'h00;
            rdata_q    <= `NFR_RST_WORD;
            rresp_q    <= `NFR_RESP_OKAY;
        end else begin
            case (rd_state_q)
                NFR_RD_IDLE: begin
                    if (ar_hs) begin
                        ridx_q  <= ridx;
                        rdata_q <= rd_mux;
                        rresp_q <= idx_ok(ridx) ? `NFR_RESP_OKAY
                                                : `NFR_RESP_SLVERR;
                        // answer waits for the calibration result
                        if (ridx == `NFR_IDX_GAIN
                            && (!written_q || cal_busy)) begin
                            rd_state_q <= NFR_RD_CAL;
                        end else begin
                            rd_state_q <= NFR_RD_RESP;
                        end
                    end
                end
                NFR_RD_CAL: begin
                    if (!cal_busy) begin
                        rdata_q    <= rd_mux;
                        rd_state_q <= NFR_RD_RESP;
                    end
                end
                NFR_RD_RESP: begin
                    if (s_rready_i) begin
                        rd_state_q <= NFR_RD_IDLE;
                    end
                end
                default: rd_state_q <= NFR_RD_IDLE;
            endcase
        end
    end

    AST_FDC_RSVD: assert property ( // R16
        s_rvalid_o && ridx_q == `NFR_IDX_FDC |-> s_rdata_o[31:15] == 17'h0)
        else $error("reserved field bits not zero");

endmodule

// *** nfr_status_config_regs_bench.sv ***
`include "nfr_params.svh"
module nfr_status_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // signals
    logic clk_i = 0, rst_b_i = 0, s_awvalid_i = 0, s_wvalid_i = 0;
    logic s_bready_i = 0, s_arvalid_i = 0, s_rready_i = 0, cal_ack_i = 0;
    logic nfc_level_det_i = 0, rf_level_det_i = 0, host_param_err_i = 0;
    logic host_syntax_err_i = 0, host_semantic_err_i = 0, standby_req_i = 0;
    logic host_err_clear_i = 0, regulator_output_good_i = 1, req_n = 0;
    logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
    logic irq_o, cal_req_o, cal_fixed_gear_o, field_detected_o;
    logic near_field_detector_powerdown_o, temp_sensor_enable_o;
    logic thermal_hysteresis_enable_o;
    logic [11:0] s_awaddr_i = 0, s_araddr_i = 0;
    logic [31:0] s_wdata_i = 0, s_rdata_o, v;
    logic [3:0]  s_wstrb_i = 4'hF, cal_gear_res_i = 0, cal_gear_o;
    logic [3:0]  detection_level_setting_o, level_detector_ref_a_o;
    logic [3:0]  level_detector_ref_b_o;
    logic [1:0]  s_bresp_o, s_rresp_o, bq[$];
    logic [4:0]  boot_cause_i = 5'h05;
    logic [7:0]  temp_trip_deg_o, trip[4] = '{85, 115, 125, 135};
    logic [9:0]  cal_value_res_i = 0;
    logic [33:0] rq[$];
    int          error_cnt = 0, comparisons = 0, cyc = 0;
    integer      seed = 32'h4a9e;
    localparam logic [11:0] F = 12'(`NFR_IDX_FDC * 4), S = F + 12'h004;
    localparam logic [11:0] T = F + 12'h008, G = F + 12'h00C;
    localparam logic [11:0] IS = 12'h0C0, IM = 12'h0C4;
    always #2.5 clk_i = ~clk_i;
    nfr_status_config_regs dut (.*);
    // ==========
    // tasks
    task automatic cmp(input logic [33:0] g, e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ready sampled mid-cycle, so no race with the edge's own updates
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic ta, tw, tb;
        bq.push_back(r);
        s_awaddr_i <= a;
        s_wdata_i <= d;
        s_awvalid_i <= 1;
        s_wvalid_i <= 1;
        s_bready_i <= 1;
        do begin
            @(negedge clk_i);
            ta = s_awvalid_i & s_awready_o;
            tw = s_wvalid_i & s_wready_o;
            tb = s_bvalid_o;
            @(posedge clk_i);
            if (ta) s_awvalid_i <= 0;
            if (tw) s_wvalid_i <= 0;
            if (tb) s_bready_i <= 0;
        end while (!tb);
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        logic ta, tr;
        rq.push_back(e);
        s_araddr_i <= a;
        s_arvalid_i <= 1;
        s_rready_i <= 1;
        do begin
            @(negedge clk_i);
            ta = s_arvalid_i & s_arready_o;
            tr = s_rvalid_o;
            @(posedge clk_i);
            if (ta) s_arvalid_i <= 0;
            if (tr) s_rready_i <= 0;
        end while (!tr);
        @(posedge clk_i);
    endtask
    // ==========
    // watcher, calibration responder, timeout
    always @(negedge clk_i) begin
        req_n <= cal_req_o;
        if (s_bvalid_o & s_bready_i) cmp(s_bresp_o, bq.pop_front());
        if (s_rvalid_o & s_rready_i)
            cmp({s_rresp_o, s_rdata_o}, rq.pop_front());
    end
    always @(posedge clk_i) begin
        cal_ack_i <= req_n & ~cal_ack_i;
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ==========
    // main sequence
    initial begin
        v = $random(seed);
        cal_gear_res_i <= v[3:0];
        cal_value_res_i <= v[13:4];
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1;
        @(posedge clk_i);
        rd(S, 34'h0_0000_0205);
        rd(F, 0);
        v = $random(seed);
        wr(F, v, 0);
        rd(F, {2'b0, v & 32'h0000_7FFF});
        cmp({near_field_detector_powerdown_o, detection_level_setting_o,
             level_detector_ref_a_o, level_detector_ref_b_o},
            {v[14], v[11:0]});
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(T, {v[31:2], 2'(i)}, 0);
            rd(T, {30'h0, v[3:2], 2'(i)});
            cmp({thermal_hysteresis_enable_o, temp_sensor_enable_o,
                 temp_trip_deg_o}, {v[3:2], trip[i]});
        end
        wr(12'hFFC, v, 2'b10);
        rd(12'hFFC, 34'h2_0000_0000);
        nfc_level_det_i <= 1;
        wr(F, 32'h0000_4000, 0);
        cmp({near_field_detector_powerdown_o, field_detected_o}, 2'b10);
        for (int s = 0; s < 4; s++) begin
            rf_level_det_i <= (s == 2);
            wr(F, 32'(s) << 12, 0);
            cmp(field_detected_o, s != 1);
        end
        {host_param_err_i, host_syntax_err_i, host_semantic_err_i,
         standby_req_i} <= 4'hF;
        @(posedge clk_i);
        {host_param_err_i, host_syntax_err_i, host_semantic_err_i,
         standby_req_i} <= 4'h0;
        wr(S, 32'hFFFF_FFFF, 0);
        rd(S, 34'h0_0000_03E5);
        {host_err_clear_i, regulator_output_good_i} <= 2'b10;
        @(posedge clk_i);
        host_err_clear_i <= 0;
        rd(S, 34'h0_0000_0025);
        rd(G, {20'h0, cal_gear_res_i, cal_value_res_i});
        cmp(cal_fixed_gear_o, 0);
        v[9:0] = cal_value_res_i;
        cal_value_res_i <= ~v[9:0];
        wr(G, {18'h3_FFFF, 4'hA, v[9:0]}, 0);
        cmp({cal_fixed_gear_o, cal_gear_o}, 5'h1A);
        rd(G, {20'h0, 4'hA, ~v[9:0]});
        rd(IS, 34'h7);
        wr(IM, 32'h7, 0);
        cmp(irq_o, 1);
        wr(IS, 32'h7, 0);
        cmp(irq_o, 0);
        rd(IS, 0);
        end_of_test();
    end
endmodule
